// ### hdl/sevag_defs.svh
`ifndef SEVAG_DEFS_SVH
`define SEVAG_DEFS_SVH

// Clock rate and the re-evaluation period of persisting gauge conditions.
`define SEVAG_CLK_HZ        20000000
`define SEVAG_REEVAL_MS     500

// Serial poll status positions of the three summary flags.
`define SEVAG_SP_RELAY_BIT  0
`define SEVAG_SP_ERROR_BIT  1
`define SEVAG_SP_GAUGE_BIT  2

// Gauge status bit positions.
`define SEVAG_G_ION_LOCK    0
`define SEVAG_G_ION_RANGE   1
`define SEVAG_G_ION_FAULT   2
`define SEVAG_G_ION_OVER    3
`define SEVAG_G_ANALOG_LO   4
`define SEVAG_G_AUX1_RANGE  9
`define SEVAG_G_AUX1_FAULT  10
`define SEVAG_G_AUX2_RANGE  13
`define SEVAG_G_AUX2_FAULT  14

// Implemented bits of each status word; the rest read as zero.
`define SEVAG_GAUGE_VALID   16'h66FF
`define SEVAG_ALL_VALID     16'hFFFF

// Reset values of flags and masks.
`define SEVAG_FLAGS_RESET   16'h0000
`define SEVAG_MASK_RESET    16'h0000

`endif

// ### hdl/sevag_pkg.sv
package sevag_pkg;

  typedef enum logic [1:0] {
    SEVAG_OP_FLAGS_QUERY = 2'b00,
    SEVAG_OP_MASK_QUERY  = 2'b01,
    SEVAG_OP_MASK_WRITE  = 2'b10
  } sevag_op_t;

  typedef enum logic [1:0] {
    SEVAG_TGT_ERROR = 2'b00,
    SEVAG_TGT_GAUGE = 2'b01,
    SEVAG_TGT_RELAY = 2'b10
  } sevag_target_t;

  typedef logic [15:0] sevag_word_t;

endpackage

// ### hdl/sevag_word_if.sv
`timescale 1ns/1ps
interface sevag_word_if;
  import sevag_pkg::*;
  sevag_word_t set;
  logic        clr_all;
  logic        clr_bit;
  logic [3:0]  idx;
  logic        mask_load;
  logic        mask_bit_wr;
  sevag_word_t wdata;
  sevag_word_t flags;
  sevag_word_t mask;
  logic        summary;

  modport ctrl (output set, clr_all, clr_bit, idx, mask_load, mask_bit_wr, wdata,
                input  flags, mask, summary);
  modport word (input  set, clr_all, clr_bit, idx, mask_load, mask_bit_wr, wdata,
                output flags, mask, summary);
endinterface

// ### hdl/sevag_flag_word.sv
`timescale 1ns/1ps
`include "sevag_defs.svh"
module sevag_flag_word
  import sevag_pkg::*;
#(
  parameter sevag_word_t VALID = `SEVAG_ALL_VALID
) (
  // Clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rstn_i,
  // Word controls
  sevag_word_if.word wd
);

  typedef struct packed {
    sevag_word_t flags;
    sevag_word_t mask;
  } sevag_fw_state_t;

  sevag_fw_state_t s_q;
  sevag_fw_state_t s_d;

  function automatic sevag_word_t onehot(input logic [3:0] i);
    onehot = sevag_word_t'(1) << i;
  endfunction

  always_comb begin
    sevag_word_t clr;
    clr = '0;
    s_d = s_q;
    if (wd.clr_all) begin
      clr = '1;
    end else if (wd.clr_bit) begin
      clr = onehot(wd.idx);
    end
    // A set arriving with its clear wins, so no event is lost.
    s_d.flags = ((s_q.flags & ~clr) | wd.set) & VALID;
    if (wd.mask_load) begin
      s_d.mask = wd.wdata;
    end else if (wd.mask_bit_wr) begin
      s_d.mask[wd.idx] = wd.wdata[0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_q <= '{flags: `SEVAG_FLAGS_RESET, mask: `SEVAG_MASK_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign wd.flags   = s_q.flags;
  assign wd.mask    = s_q.mask;
  assign wd.summary = |(s_q.flags & s_q.mask);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_clear_all_empties: assert property (wd.clr_all && wd.set == '0 |=> wd.flags == '0)
    else $error("full read left flags set");
  a_clear_one_bit: assert property (wd.clr_bit && !wd.clr_all && wd.set == '0
      |=> wd.flags == ($past(wd.flags) & ~onehot($past(wd.idx))))
    else $error("indexed read did not clear exactly one bit");
  a_unused_zero: assert property ((wd.flags & ~VALID) == '0)
    else $error("unused status bit set");
  a_set_latches: assert property (wd.set != '0 |=> (wd.flags & $past(wd.set)) == ($past(wd.set) & VALID))
    else $error("set event not latched");
  a_mask_update: assert property (wd.mask_load |=> wd.mask == $past(wd.wdata))
    else $error("mask load not applied");

endmodule

// ### hdl/sevag_top.sv
`timescale 1ns/1ps
`include "sevag_defs.svh"
module sevag_top
  import sevag_pkg::*;
#(
  parameter int unsigned REEVAL_CYCLES = (`SEVAG_CLK_HZ / 1000) * `SEVAG_REEVAL_MS
) (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          rstn_i,
  // Decoded remote command
  input  wire logic          cmd_valid_i,
  input  wire sevag_op_t     cmd_op_i,
  input  wire sevag_target_t cmd_target_i,
  input  wire logic          cmd_indexed_i,
  input  wire logic [3:0]    cmd_index_i,
  input  wire sevag_word_t   cmd_value_i,
  input  wire logic          clear_status_i,
  // Query answer
  output logic               rsp_valid_o,
  output sevag_word_t        rsp_data_o,
  // Gauge conditions, high while present
  input  wire logic          ion_lockout_i,
  input  wire logic          ion_range_i,
  input  wire logic          ion_fault_i,
  input  wire logic          ion_overpressure_i,
  input  wire logic [3:0]    analog_range_i,
  input  wire logic          aux_gauge_one_range_i,
  input  wire logic          aux_gauge_one_fault_i,
  input  wire logic          aux_gauge_two_range_i,
  input  wire logic          aux_gauge_two_fault_i,
  // Error events and relay channels
  input  wire sevag_word_t   error_event_i,
  input  wire logic [7:0]    relay_active_i,
  // Serial poll
  input  wire logic [2:0]    spoll_enable_i,
  output logic [2:0]         spoll_summary_o,
  output logic               srq_o
);

  localparam int NW = 3;

  typedef struct packed {
    logic        rsp_valid;
    sevag_word_t rsp_data;
    logic [2:0]  summary;
    logic        srq;
    sevag_word_t gauge_prev;
    logic [7:0]  relay_prev;
    logic [23:0] timer;
    logic        tick;
  } sevag_state_t;

  sevag_state_t s_q;
  sevag_state_t s_d;

  sevag_word_if w [NW] ();

  sevag_word_t flags_a [NW];
  sevag_word_t mask_a  [NW];
  logic [NW-1:0] sum_a;
  sevag_word_t set_a   [NW];
  sevag_word_t gauge_cond;

  function automatic sevag_word_t pick(input sevag_word_t v, input logic idx_en, input logic [3:0] i);
    pick = idx_en ? sevag_word_t'(v[i]) : v;
  endfunction

  assign gauge_cond = {
    1'b0,
    aux_gauge_two_fault_i,
    aux_gauge_two_range_i,
    2'b00,
    aux_gauge_one_fault_i,
    aux_gauge_one_range_i,
    1'b0,
    analog_range_i,
    ion_overpressure_i,
    ion_fault_i,
    ion_range_i,
    ion_lockout_i
  };

  // Gauge bits set on a new condition at once, and on a standing one at every
  // re-evaluation tick; a read therefore clears a standing bit only briefly.
  assign set_a[SEVAG_TGT_GAUGE] = (gauge_cond & ~s_q.gauge_prev) | (gauge_cond & {16{s_q.tick}});
  assign set_a[SEVAG_TGT_ERROR] = error_event_i;
  assign set_a[SEVAG_TGT_RELAY] = {relay_active_i, relay_active_i ^ s_q.relay_prev};

  for (genvar i = 0; i < NW; i++) begin : g_word
    localparam sevag_target_t TGT = sevag_target_t'(2'(i));
    logic hit;
    assign hit = cmd_valid_i && cmd_target_i == TGT;
    assign w[i].set         = set_a[i];
    assign w[i].clr_all     = clear_status_i
                              || (hit && cmd_op_i == SEVAG_OP_FLAGS_QUERY && !cmd_indexed_i);
    assign w[i].clr_bit     = hit && cmd_op_i == SEVAG_OP_FLAGS_QUERY && cmd_indexed_i;
    assign w[i].idx         = cmd_index_i;
    assign w[i].mask_load   = hit && cmd_op_i == SEVAG_OP_MASK_WRITE && !cmd_indexed_i;
    assign w[i].mask_bit_wr = hit && cmd_op_i == SEVAG_OP_MASK_WRITE && cmd_indexed_i;
    assign w[i].wdata       = cmd_value_i;
    assign mask_a[i]        = w[i].mask;
    if (i == SEVAG_TGT_RELAY) begin : g_live
      // Active bits show the channels as they stand now. A latched active bit of a
      // channel that has since dropped must neither answer nor raise a request.
      assign flags_a[i] = {w[i].flags[15:8] & relay_active_i, w[i].flags[7:0]};
      assign sum_a[i]   = |(flags_a[i] & mask_a[i]);
    end else begin : g_held
      assign flags_a[i] = w[i].flags;
      assign sum_a[i]   = w[i].summary;
    end

    sevag_flag_word #(
      .VALID((TGT == SEVAG_TGT_GAUGE) ? `SEVAG_GAUGE_VALID : `SEVAG_ALL_VALID)
    ) u_word (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .wd    (w[i].word)
    );
  end

  always_comb begin
    s_d            = s_q;
    s_d.rsp_valid  = 1'b0;
    s_d.gauge_prev = gauge_cond;
    s_d.relay_prev = relay_active_i;
    s_d.tick       = 1'b0;
    if (s_q.timer == 24'(REEVAL_CYCLES - 1)) begin
      s_d.timer = '0;
      s_d.tick  = 1'b1;
    end else begin
      s_d.timer = s_q.timer + 24'h000001;
    end
    if (cmd_valid_i) begin
      unique case (cmd_op_i)
        SEVAG_OP_FLAGS_QUERY: begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = '0;
          if (cmd_target_i != 2'b11) begin
            s_d.rsp_data = pick(flags_a[cmd_target_i], cmd_indexed_i, cmd_index_i);
          end
        end
        SEVAG_OP_MASK_QUERY: begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = '0;
          if (cmd_target_i != 2'b11) begin
            s_d.rsp_data = pick(mask_a[cmd_target_i], cmd_indexed_i, cmd_index_i);
          end
        end
        SEVAG_OP_MASK_WRITE: begin
          s_d.rsp_valid = 1'b0;
        end
        default: begin
          s_d.rsp_valid = 1'b0;
        end
      endcase
    end
    // Summaries are taken from the live word outputs, one flop behind them.
    s_d.summary[`SEVAG_SP_RELAY_BIT] = sum_a[SEVAG_TGT_RELAY];
    s_d.summary[`SEVAG_SP_ERROR_BIT] = sum_a[SEVAG_TGT_ERROR];
    s_d.summary[`SEVAG_SP_GAUGE_BIT] = sum_a[SEVAG_TGT_GAUGE];
    // Relay active bits re-set every cycle, so enabling them holds the
    // request up for as long as the relay stays active.
    s_d.srq = |(s_d.summary & spoll_enable_i);
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid_o     = s_q.rsp_valid;
  assign rsp_data_o      = s_q.rsp_data;
  assign spoll_summary_o = s_q.summary;
  assign srq_o           = s_q.srq;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_query_answer: assert property (cmd_valid_i && cmd_op_i != SEVAG_OP_MASK_WRITE
      |=> rsp_valid_o)
    else $error("query not answered next cycle");
  a_write_silent: assert property (cmd_valid_i && cmd_op_i == SEVAG_OP_MASK_WRITE |=> !rsp_valid_o)
    else $error("mask write produced an answer");
  a_gauge_read_value: assert property (cmd_valid_i && cmd_op_i == SEVAG_OP_FLAGS_QUERY
      && cmd_target_i == SEVAG_TGT_GAUGE && !cmd_indexed_i
      |=> rsp_data_o == $past(flags_a[SEVAG_TGT_GAUGE]))
    else $error("gauge word answer differs from flags");
  a_bit_answer: assert property (cmd_valid_i && cmd_indexed_i && cmd_op_i != SEVAG_OP_MASK_WRITE
      |=> rsp_data_o[15:1] == 15'h0000)
    else $error("indexed answer wider than one bit");
  a_gauge_summary: assert property (spoll_summary_o[`SEVAG_SP_GAUGE_BIT]
      == $past(|(flags_a[SEVAG_TGT_GAUGE] & mask_a[SEVAG_TGT_GAUGE])))
    else $error("gauge summary out of step");
  a_relay_summary: assert property (spoll_summary_o[`SEVAG_SP_RELAY_BIT]
      == $past(|(flags_a[SEVAG_TGT_RELAY] & mask_a[SEVAG_TGT_RELAY])))
    else $error("relay summary out of step");
  a_srq_cause: assert property (srq_o == |(spoll_summary_o & $past(spoll_enable_i)))
    else $error("service request without enabled summary");
  a_reeval_bound: assert property (s_q.timer < 24'(REEVAL_CYCLES))
    else $error("re-evaluation timer past its period");
  a_change_latch: assert property (relay_active_i[0] != s_q.relay_prev[0]
      |=> flags_a[SEVAG_TGT_RELAY][0])
    else $error("relay change not latched");
  a_active_live: assert property (relay_active_i[0] |=> w[2].flags[8])
    else $error("relay active bit not following channel");

endmodule

// ### testbench/sevag_host.sv
`timescale 1ns/1ps
module sevag_host
  import sevag_pkg::*;
(
  // Clock and answer
  input  wire logic    mclk_i,
  input  wire logic    rsp_valid_i,
  input  wire sevag_word_t rsp_data_i,
  // Decoded command
  output sevag_op_t    cmd_op_o,
  output sevag_target_t cmd_target_o,
  output logic         cmd_valid_o,
  output logic         cmd_indexed_o,
  output logic [3:0]   cmd_index_o,
  output sevag_word_t  cmd_value_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = SEVAG_OP_MASK_QUERY;
    cmd_target_o = SEVAG_TGT_ERROR;
    cmd_indexed_o = 1'b0;
    cmd_index_o = 4'h0;
    cmd_value_o = 16'h0000;
  end

  // Between commands the fields carry the inverse of the last one, so a stale value cannot pass for a live one.
  task automatic xfer(input sevag_op_t op, input sevag_target_t tg, input logic ix, input logic [3:0] idx,
                      input sevag_word_t v, output sevag_word_t rd);
    @(negedge mclk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_target_o = tg;
    cmd_indexed_o = ix;
    cmd_index_o = idx;
    cmd_value_o = v;
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    cmd_op_o = sevag_op_t'(~op);
    cmd_target_o = sevag_target_t'(~tg);
    cmd_indexed_o = ~ix;
    cmd_index_o = ~idx;
    cmd_value_o = ~v;
    rd = rsp_valid_i ? rsp_data_i : 16'hDEAD;
  endtask
endmodule

// ### testbench/sevag_top_tb.sv
`timescale 1ns/1ps
module sevag_top_tb;
  import sevag_pkg::*;
  localparam int unsigned REEVAL = 16;
  logic          mclk_i, rstn_i, clr, rsp_valid, cmd_valid, cmd_ix, srq;
  logic [11:0]   cond;
  logic [7:0]    relay;
  logic [2:0]    sp_en, sp_sum;
  logic [3:0]    cmd_idx;
  sevag_op_t     cmd_op;
  sevag_target_t cmd_tg;
  sevag_word_t   cmd_v, rsp, err_ev, v, rd;
  int            fail_count, n_checks, cyc, k;

  sevag_top #(.REEVAL_CYCLES(REEVAL)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_target_i(cmd_tg), .cmd_indexed_i(cmd_ix), .cmd_index_i(cmd_idx),
    .cmd_value_i(cmd_v), .clear_status_i(clr), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp),
    .ion_lockout_i(cond[0]), .ion_range_i(cond[1]), .ion_fault_i(cond[2]), .ion_overpressure_i(cond[3]),
    .analog_range_i(cond[7:4]), .aux_gauge_one_range_i(cond[8]), .aux_gauge_one_fault_i(cond[9]),
    .aux_gauge_two_range_i(cond[10]), .aux_gauge_two_fault_i(cond[11]), .error_event_i(err_ev),
    .relay_active_i(relay), .spoll_enable_i(sp_en), .spoll_summary_o(sp_sum), .srq_o(srq));
  sevag_host i_host (.mclk_i(mclk_i), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp), .cmd_op_o(cmd_op),
    .cmd_target_o(cmd_tg), .cmd_valid_o(cmd_valid), .cmd_indexed_o(cmd_ix), .cmd_index_o(cmd_idx),
    .cmd_value_o(cmd_v));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A limit far beyond the expected run; reaching it means a hang.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end

  function automatic sevag_word_t gmap(input logic [11:0] c);
    return {1'b0, c[11:10], 2'b00, c[9:8], 1'b0, c[7:0]};
  endfunction

  task automatic chk_word(input string nm, input sevag_word_t e, input sevag_word_t g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic [3:0] e);
    n_checks++;
    if ({srq, sp_sum} !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, {srq, sp_sum});
    end
  endtask

  task automatic q(input sevag_op_t op, input sevag_target_t tg, input logic ix, input logic [3:0] idx,
                   input sevag_word_t e);
    i_host.xfer(op, tg, ix, idx, 16'h0000, rd);
    chk_word("answer", e, rd);
  endtask

  task automatic wr(input sevag_target_t tg, input logic ix, input logic [3:0] idx, input sevag_word_t w);
    i_host.xfer(SEVAG_OP_MASK_WRITE, tg, ix, idx, w, rd);
  endtask

  task automatic pulse(input logic [11:0] c, input sevag_word_t e);
    @(negedge mclk_i);
    cond = c;
    err_ev = e;
    @(negedge mclk_i);
    cond = 12'h000;
    err_ev = 16'h0000;
  endtask

  initial begin
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    {rstn_i, clr, cond, relay, sp_en, err_ev} = '0;
    void'($urandom(32'h1383));
    repeat (5) @(negedge mclk_i);
    rstn_i = 1'b1;
    chk_flag("reset", 4'h0);
    for (int t = 0; t < 3; t++) begin
      q(SEVAG_OP_MASK_QUERY, sevag_target_t'(t), 1'b0, 4'h0, 16'h0000);
      v = sevag_word_t'($urandom);
      if (t == 2) v[15:8] = 8'h00;
      wr(sevag_target_t'(t), 1'b0, 4'h0, v);
      q(SEVAG_OP_MASK_QUERY, sevag_target_t'(t), 1'b0, 4'h0, v);
      k = (t == 2) ? $urandom % 8 : $urandom % 16;
      v[k] = ~v[k];
      wr(sevag_target_t'(t), 1'b1, 4'(k), {15'h0000, v[k]});
      q(SEVAG_OP_MASK_QUERY, sevag_target_t'(t), 1'b1, 4'(k), {15'h0000, v[k]});
      q(SEVAG_OP_MASK_QUERY, sevag_target_t'(t), 1'b0, 4'h0, v);
      wr(sevag_target_t'(t), 1'b0, 4'h0, 16'h0000);
    end
    q(SEVAG_OP_MASK_QUERY, sevag_target_t'(2'b11), 1'b0, 4'h0, 16'h0000);
    repeat (8) begin
      cond = 12'($urandom);
      v = gmap(cond);
      pulse(cond, 16'h0000);
      q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, v);
      q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h0000);
    end
    pulse(12'hF11, 16'h0000);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b1, 4'h0, 16'h0001);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h6610);
    cond = 12'h002;
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h0002);
    repeat (REEVAL + 2) @(negedge mclk_i);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h0002);
    cond = 12'h000;
    i_host.xfer(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h0000, rd);
    wr(SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h0010);
    sp_en = 3'b100;
    pulse(12'h010, 16'h0000);
    repeat (2) @(negedge mclk_i);
    chk_flag("gauge_sum", 4'hC);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h0010);
    repeat (2) @(negedge mclk_i);
    chk_flag("gauge_drop", 4'h0);
    wr(SEVAG_TGT_ERROR, 1'b0, 4'h0, 16'h0020);
    sp_en = 3'b001;
    pulse(12'h000, 16'h0020);
    repeat (2) @(negedge mclk_i);
    chk_flag("error_sum", 4'h2);
    repeat (6) begin
      v = sevag_word_t'($urandom);
      pulse(12'h000, v);
      q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_ERROR, 1'b0, 4'h0, v);
      q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_ERROR, 1'b0, 4'h0, 16'h0000);
    end
    pulse(12'h000, 16'h0C00);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_ERROR, 1'b1, 4'hA, 16'h0001);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_ERROR, 1'b0, 4'h0, 16'h0800);
    wr(SEVAG_TGT_RELAY, 1'b0, 4'h0, 16'h0001);
    relay = 8'hA5;
    repeat (3) @(negedge mclk_i);
    chk_flag("relay_sum", 4'h9);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_RELAY, 1'b0, 4'h0, 16'hA5A5);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_RELAY, 1'b0, 4'h0, 16'hA500);
    relay = 8'h24;
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_RELAY, 1'b1, 4'h0, 16'h0001);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_RELAY, 1'b0, 4'h0, 16'h2480);
    pulse(12'h004, 16'h0001);
    relay = 8'h00;
    @(negedge mclk_i);
    clr = 1'b1;
    @(negedge mclk_i);
    clr = 1'b0;
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_GAUGE, 1'b0, 4'h0, 16'h0000);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_ERROR, 1'b0, 4'h0, 16'h0000);
    q(SEVAG_OP_FLAGS_QUERY, SEVAG_TGT_RELAY, 1'b0, 4'h0, 16'h0000);
    stop_test();
  end
endmodule
